// *** logic/hdirq_pkg.sv ***
// package: register map, field layout and event record for the link irq block
package hdirq_pkg;
   // register byte addresses (word aligned)
   localparam logic [7:0] ADDR_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RXFILL = 8'h08;
   // field positions inside the enable and status registers
   localparam int BIT_IDLE = 0;
   localparam int BIT_ABORT = 1;
   localparam int BIT_FCS = 2;
   localparam int BIT_RX_DONE = 3;
   localparam int BIT_TX_DONE = 4;
   localparam int BIT_RX_BEGIN = 5;
   localparam int BIT_TX_BEGIN = 6;
   localparam int BIT_TYPE = 7;
   // writable mask, reset values, flag octet and abort run length
   localparam logic [7:0] ENABLE_MASK = 8'h7F;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] FLAG_OCTET = 8'h7E;
   localparam logic [2:0] ABORT_ONES = 3'h7;
   localparam logic [1:0] RST_SYNC_RESET = 2'h0;

   // inputs from the framing datapath: one-cycle event pulses, then the received bit and its valid
   typedef struct packed {
      logic tx_msg_begin_event;
      logic rx_msg_begin_event;
      logic tx_msg_done_event;
      logic rx_msg_done_event;
      logic rx_buffer_full;
      logic frame_check_fail;
      logic rx_bit_valid;
      logic rx_bit;
   } hdirq_events_t;
endpackage : hdirq_pkg

// *** logic/hdirq_rx_watch.sv ***
// receive bit watcher: finds abort run and flag octet on the link bits
`timescale 1ns/10ps
module hdirq_rx_watch (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   output logic abort_o,
   output logic idle_o
);
   logic [7:0] shift;
   logic [2:0] ones;
   wire logic [7:0] next_shift = {shift[6:0], bit_i};
   wire logic saturated = (ones == hdirq_pkg::ABORT_ONES);

   // ones counter and octet shifter advance only on valid bits
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift <= 8'h00;
         ones <= 3'h0;
      end else if (bit_valid_i) begin
         shift <= next_shift;
         ones <= bit_i ? (saturated ? ones : 3'(ones + 3'h1)) : 3'h0;
      end
   end

   // pulse on the seventh consecutive one, not on longer runs
   assign abort_o = bit_valid_i && bit_i &&
                    (ones == 3'(hdirq_pkg::ABORT_ONES - 3'h1));
   // flag octet compared as bits arrive, any alignment
   assign idle_o = bit_valid_i &&
                   (next_shift == hdirq_pkg::FLAG_OCTET);
endmodule : hdirq_rx_watch

// *** logic/hdirq_top.sv ***
// top: wishbone slave with link interrupt enable and status registers
//
// Behaviour
// - transmit-start event raises interrupt when its enable bit is set
// - receive-start event raises interrupt when its enable bit is set
// - transmit-end event raises interrupt when its enable bit is set
// - receive-end event raises interrupt when its enable bit is set
// - frame check error raises interrupt when its enable bit is set
// - seven consecutive received ones raise abort interrupt when enabled
// - received flag octet 0x7E raises idle interrupt when enabled
// - enable bits read/write, reset to zero, zero suppresses the interrupt
// - status bits 6:0 latch events and clear when status is read
// - receive buffer full also declares the receive-end event
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module hdirq_top (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire hdirq_pkg::hdirq_events_t events_i,
   input wire logic msg_type_i,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic [1:0] rst_sync;
   wire logic rst_n = rst_sync[1];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         rst_sync <= hdirq_pkg::RST_SYNC_RESET;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   ////////////////////////////////////////////////////////////////////
   // bus decode; single-cycle ack, unmapped addresses answer with err
   logic [7:0] enable;
   logic [7:0] status;
   logic rx_fill_count_en;
   logic [7:0] rx_fill_events;
   logic answered;
   wire logic req = wb_cyc_i && wb_stb_i && !answered;
   wire logic hit_en = (wb_adr_i == hdirq_pkg::ADDR_ENABLE);
   wire logic hit_st = (wb_adr_i == hdirq_pkg::ADDR_STATUS);
   wire logic hit_fc = (wb_adr_i == hdirq_pkg::ADDR_RXFILL);
   wire logic mapped = hit_en || hit_st || hit_fc;
   wire logic wr_en = req && wb_we_i && hit_en && wb_sel_i[0];
   wire logic wr_fc = req && wb_we_i && hit_fc && wb_sel_i[0];
   wire logic rd_st = req && !wb_we_i && hit_st;

   // ack/err one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         answered <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         answered <= req;
         wb_ack_o <= req && mapped;
         wb_err_o <= req && !mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // enable register; reserved top bit held at zero
   wire logic [7:0] next_enable = wb_dat_i[7:0] &
                                  hdirq_pkg::ENABLE_MASK;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         enable <= hdirq_pkg::ENABLE_RESET;
      else if (wr_en)
         enable <= next_enable;
   end

   // spare control: counts buffer-full declarations (diagnostic)
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_fill_count_en <= 1'b0;
         rx_fill_events <= 8'h00;
      end else if (wr_fc) begin
         rx_fill_count_en <= wb_dat_i[0];
         rx_fill_events <= 8'h00;
      end else if (rx_fill_count_en && events_i.rx_buffer_full &&
                   rx_fill_events != 8'hFF) begin
         rx_fill_events <= 8'(rx_fill_events + 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event sources
   logic abort_seen;
   logic idle_seen;

   hdirq_rx_watch hdirq_rx_watch_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .bit_valid_i(events_i.rx_bit_valid),
      .bit_i(events_i.rx_bit),
      .abort_o(abort_seen),
      .idle_o(idle_seen)
   );

   // raw event vector in status bit order; bit 7 is the type bit
   logic [6:0] raw;
   assign raw[hdirq_pkg::BIT_TX_BEGIN] = events_i.tx_msg_begin_event;
   assign raw[hdirq_pkg::BIT_RX_BEGIN] = events_i.rx_msg_begin_event;
   assign raw[hdirq_pkg::BIT_TX_DONE] = events_i.tx_msg_done_event;
   assign raw[hdirq_pkg::BIT_RX_DONE] = events_i.rx_msg_done_event ||
                                        events_i.rx_buffer_full;
   assign raw[hdirq_pkg::BIT_FCS] = events_i.frame_check_fail;
   assign raw[hdirq_pkg::BIT_ABORT] = abort_seen;
   assign raw[hdirq_pkg::BIT_IDLE] = idle_seen;

   ////////////////////////////////////////////////////////////////////
   // sticky status, cleared on read; a set in the read cycle wins
   wire logic [6:0] keep = rd_st ? 7'h00 : status[6:0];
   wire logic [6:0] next_status = keep | raw;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         status <= hdirq_pkg::STATUS_RESET;
      else
         status <= {msg_type_i, next_status};
   end

   // interrupt: any latched event whose enable is set
   wire logic [6:0] pending = status[6:0] & enable[6:0];
   // enable as it stands after this edge, so irq tracks a write at once
   wire logic [7:0] enable_d = wr_en ? next_enable : enable;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         irq_o <= 1'b0;
      else
         irq_o <= |(next_status & enable_d[6:0]);
   end

   ////////////////////////////////////////////////////////////////////
   // read data, registered with the ack
   wire logic [31:0] rd_mux =
      hit_en ? {24'h000000, enable} :
      hit_st ? {24'h000000, status} :
      hit_fc ? {23'h0, rx_fill_events, rx_fill_count_en} :
      32'h00000000;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         wb_dat_o <= 32'h00000000;
      else if (req && !wb_we_i)
         wb_dat_o <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
      !enable[7]) else $error("reserved enable bit set");
   a_enable_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_en |=> enable == ($past(wb_dat_i[7:0]) & 8'h7F))
      else $error("enable write lost");
   a_irq_follows: assert property (@(posedge clk_i) disable iff (!rst_n)
      irq_o == |pending) else $error("irq not from pending");
   a_status_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_st && raw == 7'h00 |=> status[6:0] == 7'h00)
      else $error("status not cleared on read");
   a_event_sticks: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_TX_DONE] |=> status[hdirq_pkg::BIT_TX_DONE])
      else $error("tx done lost");
   a_full_declares: assert property (@(posedge clk_i) disable iff (!rst_n)
      events_i.rx_buffer_full |=> status[hdirq_pkg::BIT_RX_DONE])
      else $error("buffer full not declared");
   a_disabled_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
      enable == 8'h00 && !wr_en |=> !irq_o)
      else $error("irq while disabled");
   a_rx_begin_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_RX_BEGIN] && enable[hdirq_pkg::BIT_RX_BEGIN] &&
      !wr_en |=> irq_o) else $error("rx begin irq missing");
   a_tx_begin_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_TX_BEGIN] && enable[hdirq_pkg::BIT_TX_BEGIN] &&
      !wr_en |=> irq_o) else $error("tx begin irq missing");
   a_fcs_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_FCS] && enable[hdirq_pkg::BIT_FCS] &&
      !wr_en |=> irq_o) else $error("fcs irq missing");
   a_rx_done_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_RX_DONE] && enable[hdirq_pkg::BIT_RX_DONE] &&
      !wr_en |=> irq_o) else $error("rx done irq missing");
   a_abort_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
      abort_seen |=> status[hdirq_pkg::BIT_ABORT])
      else $error("abort not latched");
   a_idle_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
      idle_seen |=> status[hdirq_pkg::BIT_IDLE])
      else $error("idle not latched");
   // remaining sources, read-cycle race and register upkeep
   a_rx_begin_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_RX_BEGIN] |=> status[hdirq_pkg::BIT_RX_BEGIN])
      else $error("rx begin not latched");
   a_fcs_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_FCS] |=> status[hdirq_pkg::BIT_FCS])
      else $error("fcs not latched");
   a_tx_done_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      raw[hdirq_pkg::BIT_TX_DONE] && enable[hdirq_pkg::BIT_TX_DONE] &&
      !wr_en |=> irq_o) else $error("tx done irq missing");
   a_abort_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      abort_seen && enable[hdirq_pkg::BIT_ABORT] && !wr_en |=> irq_o)
      else $error("abort irq missing");
   a_idle_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
      idle_seen && enable[hdirq_pkg::BIT_IDLE] && !wr_en |=> irq_o)
      else $error("idle irq missing");
   a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_st |=> status[6:0] == $past(raw))
      else $error("event lost in read cycle");
   a_enable_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      !wr_en |=> $stable(enable))
      else $error("enable changed without write");
   a_reserved_read: assert property (@(posedge clk_i) disable iff (!rst_n)
      wb_ack_o && $past(req && !wb_we_i && hit_en) |-> !wb_dat_o[7])
      else $error("reserved enable bit read as one");
endmodule : hdirq_top

// *** bench/hdirq_link_far.sv ***
// far-end link model: serial bit source feeding the receive watcher
`timescale 1ns/10ps
module hdirq_link_far (
   input wire logic clk_i,
   output logic bit_valid_o,
   output logic bit_o
);
   // line starts idle with no valid bit
   initial begin
      bit_valid_o = 1'b0;
      bit_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // msb first; after a burst valid drops so stale bits never pass, and the data line flips
   task automatic send(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         bit_valid_o <= 1'b1;
         bit_o <= b[7 - i];
      end
      @(posedge clk_i);
      bit_valid_o <= 1'b0;
      bit_o <= ~bit_o;
   endtask : send
endmodule : hdirq_link_far

// *** bench/test_hdirq_top.sv ***
// testbench: register access, event gating and status clearing
`timescale 1ns/10ps
module test_hdirq_top;
   logic clk_i, resetn_i, cyc, stb, we, ack, err, irq, pv, pb, e, mt;
   logic [7:0] adr, pulse;
   logic [31:0] wdat, rdat, q;
   int n_fail, checks_done, cycles;
   int evb[6] = '{7, 6, 5, 4, 3, 2};
   int stp[6] = '{6, 5, 4, 3, 3, 2};
   hdirq_pkg::hdirq_events_t ev;
   // event pulses from the bench, serial bits from the far end
   assign ev = {pulse[7:2], pv, pb};
   hdirq_top hdirq_top_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .events_i(ev), .msg_type_i(mt), .irq_o(irq));
   hdirq_link_far hdirq_link_far_inst (.clk_i(clk_i), .bit_valid_o(pv),
      .bit_o(pb));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard; 3000 cycles is about twenty times the planned run
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task automatic chk32(input string nm, input logic [31:0] x, y);
      checks_done++;
      if (y !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, x, y);
      end
   endtask : chk32
   task automatic chk1(input string nm, input logic x, y);
      checks_done++;
      if (y !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %b seen %b", nm, x, y);
      end
   endtask : chk1
   // one classic cycle; held until ack or err, only the hang guard stops it
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input string nm);
      bus(1'b0, a, 32'h0);
      chk32(nm, x, q);
   endtask : rd
   // pulse one event field, then look at the interrupt line
   task automatic pulse_ev(input int b, input logic x);
      @(posedge clk_i);
      pulse[b] <= 1'b1;
      @(posedge clk_i);
      pulse[b] <= 1'b0;
      #1;
      chk1("irq", x, irq);
   endtask : pulse_ev
   ////////////////////////////////////////////////////////////////////////
   // main sequence; status bit 7 shows the bench-driven message type
   initial begin
      resetn_i = 1'b0;
      {cyc, stb, we, mt} = 4'h1;
      adr = 8'h00;
      wdat = 32'h0;
      pulse = 8'h00;
      {n_fail, checks_done, cycles} = 0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(hdirq_pkg::ADDR_ENABLE, 32'h0, "enable reset");
      rd(hdirq_pkg::ADDR_STATUS, 32'h80, "status reset");
      bus(1'b1, hdirq_pkg::ADDR_ENABLE, 32'hFF);
      rd(hdirq_pkg::ADDR_ENABLE, 32'h7F, "enable rw");
      bus(1'b1, hdirq_pkg::ADDR_RXFILL, 32'h1);
      for (int k = 0; k < 6; k++) begin
         pulse_ev(evb[k], 1'b1);
         rd(hdirq_pkg::ADDR_STATUS, 32'h80 | (32'h1 << stp[k]), "event");
         rd(hdirq_pkg::ADDR_STATUS, 32'h80, "clear on read");
         chk1("irq cleared", 1'b0, irq);
      end
      hdirq_link_far_inst.send(8'hFF, 7);
      repeat (3) @(posedge clk_i);
      chk1("irq abort", 1'b1, irq);
      rd(hdirq_pkg::ADDR_STATUS, 32'h82, "abort run");
      hdirq_link_far_inst.send(8'h7E, 8);
      repeat (3) @(posedge clk_i);
      rd(hdirq_pkg::ADDR_STATUS, 32'h81, "flag octet");
      bus(1'b1, hdirq_pkg::ADDR_ENABLE, 32'h0);
      for (int k = 0; k < 6; k++) pulse_ev(evb[k], 1'b0);
      bus(1'b1, hdirq_pkg::ADDR_ENABLE, 32'h4);
      chk1("irq on enable", 1'b1, irq);
      rd(hdirq_pkg::ADDR_STATUS, 32'hFC, "masked latch");
      chk1("irq dropped", 1'b0, irq);
      rd(hdirq_pkg::ADDR_RXFILL, 32'h5, "full count");
      bus(1'b1, hdirq_pkg::ADDR_RXFILL, 32'h0);
      rd(hdirq_pkg::ADDR_RXFILL, 32'h0, "count clear");
      bus(1'b1, hdirq_pkg::ADDR_STATUS, 32'hFF);
      rd(hdirq_pkg::ADDR_STATUS, 32'h80, "status write");
      mt <= 1'b0;
      rd(hdirq_pkg::ADDR_STATUS, 32'h00, "message type");
      bus(1'b0, 8'h40, 32'h0);
      chk1("unmapped err", 1'b1, e);
      summarize();
   end
endmodule : test_hdirq_top
